// ---- src/ern_event_router.sv ----
// event routing network: generator select per channel, sync and async subchannels,
// software events, per-user channel select and the timer and amplifier user inputs
// assumes all inputs are synchronous to sys_clk_in except asynchronous generators
// What this block does
// - each user picks one channel by own select
// - async users respond without any clock edge
// - async edge/level users carry own synchroniser
// - some async users take signal directly, undetected
// - periodic ticks divide prescaled clock 64..8192
// - logic block outputs routed as async levels
// - comparator outputs routed as async levels
// - zero-cross outputs routed as async levels
// - any pin selectable as async level event
// - baud and serial clocks: levels, two cycles min
// - timer overflow/underflow events are one-cycle pulses
// - timer compare events are one-cycle pulses
// - lookup table inputs take events undetected
// - pin outputs forward selected channel unaltered
// - count input: rise, any edge, or high
// - either timer input may steer count direction
// - restart input: rise, any edge, or high
// - capture input edge detected, single-shot async too
// - amplifier enable async edge, others synchronous
// - one generator per channel, none after reset
// - async generators synchronised, two to three cycles
// - software event inverts channel one cycle per cycle held
`timescale 1ns/100ps
`include "ern_defines.svh"

module ern_event_router #(
    parameter int NCH = 6,
    parameter int NGEN_EXT = 32,
    parameter int SELW = 8,
    parameter int CSW = 4,
    parameter int NUSER = 16,
    parameter int NPORT = 4,
    parameter logic [NGEN_EXT-1:0] GEN_ASYNC_MASK = '0,
    parameter logic [NGEN_EXT-1:0] GEN_PULSE_MASK = '0,
    parameter logic [NGEN_EXT-1:0] GEN_MIN2_MASK = '0
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [NGEN_EXT-1:0] gen_event_in,
    input wire logic rtc_tick_in,
    output logic [`ERN_PIT_TAP_COUNT-1:0] periodic_tick_out,
    input wire logic [NCH*SELW-1:0] chan_sel_in,
    input wire logic [NCH-1:0] sw_event_in,
    input wire logic [NUSER*CSW-1:0] user_sel_in,
    output logic [NUSER-1:0] user_async_out,
    output logic [NUSER-1:0] user_sync_out,
    input wire logic [NPORT*CSW-1:0] event_pin_sel_in,
    output logic [NPORT-1:0] event_pin_output_out,
    input wire logic [CSW-1:0] count_sel_in,
    input wire ern_pkg::ern_det_mode_t count_mode_in,
    input wire logic count_dir_en_in,
    input wire logic [CSW-1:0] restart_sel_in,
    input wire ern_pkg::ern_det_mode_t restart_mode_in,
    input wire logic restart_dir_en_in,
    output logic count_step_out,
    output logic count_down_out,
    output logic restart_out,
    input wire logic [CSW-1:0] capture_sel_in,
    input wire logic capture_async_in,
    output logic capture_edge_out,
    input wire logic [CSW-1:0] amp_enable_sel_in,
    input wire logic [CSW-1:0] amp_disable_sel_in,
    input wire logic [CSW-1:0] amp_dump_sel_in,
    input wire logic [CSW-1:0] amp_drive_sel_in,
    output logic amp_enable_out,
    output logic amp_disable_out,
    output logic amp_dump_out,
    output logic amp_drive_out
);
    localparam int NGEN = NGEN_EXT + `ERN_PIT_TAP_COUNT;

    // select widths must reach every channel and generator
    generate
        if (NCH < 1 || NCH > (2 ** CSW) - 1 || NGEN > (2 ** SELW) - 1 || NPORT > NUSER) begin : g_bad_cfg
            $error("ern_event_router: select widths too narrow for channel or generator count");
        end
    endgenerate

    logic [NGEN-1:0] gen_all;
    logic [NGEN-1:0] gen_async_all;
    logic [NCH-1:0] chan_raw;
    logic [NCH-1:0] chan_is_async;
    logic [NCH-1:0] sy1;
    logic [NCH-1:0] sy2;
    logic [NCH-1:0] sw_pend;
    logic [NCH-1:0] chan_sync_pre;
    logic [NCH-1:0] chan_async;
    logic [NCH-1:0] chan_sync;

    // generator code g+1 selects generator g, code zero leaves channel off
    function automatic logic pick_gen(input logic [SELW-1:0] sel, input logic [NGEN-1:0] v);
        logic r;
        r = 1'b0;
        for (int i = 0; i < NGEN; i++) begin
            if (sel == SELW'(i + 1)) begin
                r = v[i];
            end
        end
        return r;
    endfunction : pick_gen

    // channel code n+1 selects channel n; zero or out of range reads inactive
    function automatic logic pick_chan(input logic [CSW-1:0] sel, input logic [NCH-1:0] v);
        logic r;
        r = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if (sel == CSW'(i + 1)) begin
                r = v[i];
            end
        end
        return r;
    endfunction : pick_chan

    // counter ticks are divided on sys_clk_in from the rtc_tick_in strobe, yet are treated as asynchronous
    ern_tick_divider u_ticks (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .rtc_tick_in(rtc_tick_in),
        .periodic_tick_out(periodic_tick_out)
    );

    // pins, comparators, zero-cross and logic outputs arrive as plain async levels
    assign gen_all = {periodic_tick_out, gen_event_in};
    assign gen_async_all = {{`ERN_PIT_TAP_COUNT{1'b1}}, GEN_ASYNC_MASK};

    // generator multiplexer per channel
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_chan
            assign chan_raw[c] = pick_gen(chan_sel_in[c*SELW +: SELW], gen_all);
            assign chan_is_async[c] = pick_gen(chan_sel_in[c*SELW +: SELW], gen_async_all);
        end
    endgenerate

    // two-stage synchroniser and software pulse; sy1 feeds sy2 only
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sy1 <= '0;
            sy2 <= '0;
            sw_pend <= '0;
        end else begin
            sy1 <= chan_raw;
            sy2 <= sy1;
            sw_pend <= sw_event_in;
        end
    end

    // sync subchannel: clocked generators pass straight, others via synchroniser;
    // an async pulse shorter than a cycle may be lost here
    assign chan_sync_pre = (chan_is_async & sy2) | (~chan_is_async & chan_raw);
    // software event flips the current level one cycle later, for as many cycles as sw_event_in was high
    assign chan_async = chan_raw ^ sw_pend;
    assign chan_sync = chan_sync_pre ^ sw_pend;

    // generic users and pin outputs; async path is pure logic, needs no clock
    generate
        for (genvar u = 0; u < NUSER; u++) begin : g_user
            assign user_async_out[u] = pick_chan(user_sel_in[u*CSW +: CSW], chan_async);
            assign user_sync_out[u] = pick_chan(user_sel_in[u*CSW +: CSW], chan_sync);
        end
        for (genvar p = 0; p < NPORT; p++) begin : g_pin
            assign event_pin_output_out[p] = pick_chan(event_pin_sel_in[p*CSW +: CSW], chan_async);
        end
    endgenerate

    logic count_lvl;
    logic restart_lvl;
    logic capture_sync_lvl;
    logic capture_async_lvl;
    logic amp_en_lvl;
    logic amp_dis_lvl;
    logic cap_sync_edge;
    logic cap_async_edge;
    logic count_lvl_seen;
    logic restart_lvl_seen;

    // timer and amplifier users read their selected channel
    assign count_lvl = pick_chan(count_sel_in, chan_sync);
    assign restart_lvl = pick_chan(restart_sel_in, chan_sync);
    assign capture_sync_lvl = pick_chan(capture_sel_in, chan_sync);
    assign capture_async_lvl = pick_chan(capture_sel_in, chan_async);
    assign amp_en_lvl = pick_chan(amp_enable_sel_in, chan_async);
    assign amp_dis_lvl = pick_chan(amp_disable_sel_in, chan_sync);

    // count input: rising, any edge or while high
    ern_event_detect #(.USE_SYNC(1'b0)) u_count (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .ev_in(count_lvl),
        .mode_in(count_mode_in),
        .level_out(count_lvl_seen),
        .trig_out(count_step_out)
    );

    // restart input: same three choices
    ern_event_detect #(.USE_SYNC(1'b0)) u_restart (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .ev_in(restart_lvl),
        .mode_in(restart_mode_in),
        .level_out(restart_lvl_seen),
        .trig_out(restart_out)
    );

    // capture: synchronous edge path, used while capture_async_in is low
    ern_event_detect #(.USE_SYNC(1'b0)) u_cap_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .ev_in(capture_sync_lvl),
        .mode_in(ern_pkg::ERN_DET_RISE),
        .level_out(),
        .trig_out(cap_sync_edge)
    );

    // capture: async single-shot carries its own synchroniser
    ern_event_detect #(.USE_SYNC(1'b1)) u_cap_async (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .ev_in(capture_async_lvl),
        .mode_in(ern_pkg::ERN_DET_RISE),
        .level_out(),
        .trig_out(cap_async_edge)
    );

    assign capture_edge_out = capture_async_in ? cap_async_edge : cap_sync_edge;

    // amplifier enable accepts async edges through its own synchroniser
    ern_event_detect #(.USE_SYNC(1'b1)) u_amp_en (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .ev_in(amp_en_lvl),
        .mode_in(ern_pkg::ERN_DET_RISE),
        .level_out(),
        .trig_out(amp_enable_out)
    );

    // amplifier disable is a synchronous edge
    ern_event_detect #(.USE_SYNC(1'b0)) u_amp_dis (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .ev_in(amp_dis_lvl),
        .mode_in(ern_pkg::ERN_DET_RISE),
        .level_out(),
        .trig_out(amp_disable_out)
    );

    // direction and the two amplifier levels, registered
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            count_down_out <= 1'b0;
            amp_dump_out <= 1'b0;
            amp_drive_out <= 1'b0;
        end else begin
            count_down_out <= (count_dir_en_in & count_lvl_seen) | (restart_dir_en_in & restart_lvl_seen);
            amp_dump_out <= pick_chan(amp_dump_sel_in, chan_sync);
            amp_drive_out <= pick_chan(amp_drive_sel_in, chan_sync);
        end
    end

    // checks on the routing fabric
    property p_user_off;
        @(posedge sys_clk_in) disable iff (rst_in)
        (user_sel_in[NUSER*CSW-1 -: CSW] == CSW'(`ERN_SEL_NONE)) |->
            (!user_async_out[NUSER-1] && !user_sync_out[NUSER-1]);
    endproperty
    a_user_off: assert property (p_user_off) else $error("unselected user saw an active event");

    property p_chan_off;
        @(posedge sys_clk_in) disable iff (rst_in)
        (chan_sel_in[SELW-1:0] == SELW'(`ERN_SEL_NONE)) && !sw_pend[0] |-> !chan_async[0] && !chan_sync[0];
    endproperty
    a_chan_off: assert property (p_chan_off) else $error("channel 0 active with no generator");

    property p_sw_invert;
        @(posedge sys_clk_in) disable iff (rst_in)
        sw_event_in[0] |=> (chan_async[0] != chan_raw[0]) ##1 (sw_event_in[0] || chan_async[0] == chan_raw[0]);
    endproperty
    a_sw_invert: assert property (p_sw_invert) else $error("software event did not invert for one cycle");

    property p_sync_delay;
        @(posedge sys_clk_in) disable iff (rst_in)
        chan_is_async[0] && $rose(chan_raw[0]) && $stable(chan_sel_in[SELW-1:0])
            ##1 chan_raw[0] && $stable(chan_sel_in[SELW-1:0])
            ##1 $stable(chan_sel_in[SELW-1:0]) |-> chan_sync_pre[0] && $past(!chan_sync_pre[0]);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("async generator not synchronised in two cycles");

    property p_sync_direct;
        @(posedge sys_clk_in) disable iff (rst_in)
        !chan_is_async[0] |-> chan_sync_pre[0] == chan_raw[0];
    endproperty
    a_sync_direct: assert property (p_sync_direct) else $error("clocked generator delayed on sync subchannel");

    property p_count_rise;
        @(posedge sys_clk_in) disable iff (rst_in)
        count_mode_in == ern_pkg::ERN_DET_RISE && $rose(count_lvl) |=> count_step_out ##1 !count_step_out;
    endproperty
    a_count_rise: assert property (p_count_rise) else $error("count step missing after rising event");

    property p_restart_any;
        @(posedge sys_clk_in) disable iff (rst_in)
        restart_mode_in == ern_pkg::ERN_DET_ANY && $changed(restart_lvl) |=> restart_out;
    endproperty
    a_restart_any: assert property (p_restart_any) else $error("restart missed an event edge");

    property p_count_dir;
        @(posedge sys_clk_in) disable iff (rst_in)
        count_dir_en_in && count_lvl |=> count_down_out;
    endproperty
    a_count_dir: assert property (p_count_dir) else $error("count direction ignored event level");

    property p_amp_enable;
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(amp_en_lvl) ##1 amp_en_lvl ##1 amp_en_lvl |=> amp_enable_out;
    endproperty
    a_amp_enable: assert property (p_amp_enable) else $error("amplifier enable edge lost in synchroniser");

    property p_capture;
        @(posedge sys_clk_in) disable iff (rst_in)
        !capture_async_in && $rose(capture_sync_lvl) ##1 !capture_async_in |-> capture_edge_out;
    endproperty
    a_capture: assert property (p_capture) else $error("capture edge not reported");

    // clocked generator checks: pulses last one cycle, clock levels at least two
    generate
        for (genvar g = 0; g < NGEN_EXT; g++) begin : g_gen_chk
            if (GEN_PULSE_MASK[g]) begin : g_pulse
                property p_gen_pulse;
                    @(posedge sys_clk_in) disable iff (rst_in)
                    $rose(gen_event_in[g]) |=> !gen_event_in[g];
                endproperty
                a_gen_pulse: assert property (p_gen_pulse) else $error("timer pulse event wider than a cycle");
            end
            if (GEN_MIN2_MASK[g]) begin : g_min2
                property p_gen_min2;
                    @(posedge sys_clk_in) disable iff (rst_in)
                    $changed(gen_event_in[g]) |=> $stable(gen_event_in[g]);
                endproperty
                a_gen_min2: assert property (p_gen_min2) else $error("clock level event shorter than two cycles");
            end
        end
    endgenerate

endmodule : ern_event_router

// ---- common/ern_defines.svh ----
// constants shared by the event routing network files
// assumes inclusion by bare name from any design file
`ifndef ERN_DEFINES_SVH
`define ERN_DEFINES_SVH

// selection code zero means "not connected"
`define ERN_SEL_NONE 0
// periodic ticks: first counter bit gives divide by 64, eight taps up to 8192
`define ERN_PIT_FIRST_TAP 5
`define ERN_PIT_TAP_COUNT 8
`define ERN_PIT_CNT_W 13
// synchroniser depth and the resulting delay window in cycles
`define ERN_SYNC_STAGES 2
`define ERN_SYNC_DELAY_MIN 2
`define ERN_SYNC_DELAY_MAX 3
// shortest level of a clocked level generator, in clock periods
`define ERN_MIN_LEVEL_CYCLES 2

`endif

// ---- common/ern_pkg.sv ----
// types of the event routing network
// assumes nothing of its surroundings
package ern_pkg;

    // detection mode of a user input, one-hot
    typedef enum logic [2:0] {
        ERN_DET_RISE = 3'b001,
        ERN_DET_ANY = 3'b010,
        ERN_DET_HIGH = 3'b100
    } ern_det_mode_t;

endpackage : ern_pkg

// ---- src/ern_event_detect.sv ----
// edge or level detector for one event user input
// assumes ev_in is synchronous unless USE_SYNC is set
`timescale 1ns/100ps
`include "ern_defines.svh"

module ern_event_detect #(
    parameter bit USE_SYNC = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic ev_in,
    input wire ern_pkg::ern_det_mode_t mode_in,
    output logic level_out,
    output logic trig_out
);
    logic ev;
    logic prev;
    logic next_trig;

    // optional own synchroniser for users that accept asynchronous events
    generate
        if (USE_SYNC) begin : g_sync
            logic [`ERN_SYNC_STAGES-1:0] sy;
            always_ff @(posedge sys_clk_in) begin
                if (rst_in) begin
                    sy <= '0;
                end else begin
                    sy <= {sy[`ERN_SYNC_STAGES-2:0], ev_in};
                end
            end
            assign ev = sy[`ERN_SYNC_STAGES-1];
        end else begin : g_direct
            assign ev = ev_in;
        end
    endgenerate

    // mode decode; an unknown code never triggers
    always_comb begin
        case (mode_in)
            ern_pkg::ERN_DET_RISE: next_trig = ev & ~prev;
            ern_pkg::ERN_DET_ANY: next_trig = ev ^ prev;
            ern_pkg::ERN_DET_HIGH: next_trig = ev;
            default: next_trig = 1'b0;
        endcase
    end

    // registered so the user sees a clean pulse, one cycle in the edge modes, held while high in ERN_DET_HIGH
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            prev <= 1'b0;
            trig_out <= 1'b0;
        end else begin
            prev <= ev;
            trig_out <= next_trig;
        end
    end

    assign level_out = ev;

endmodule : ern_event_detect

// ---- src/ern_tick_divider.sv ----
// periodic tick generator: square waves of the prescaled tick divided by powers of two
// assumes rtc_tick_in is a one-cycle strobe per prescaled counter clock
`timescale 1ns/100ps
`include "ern_defines.svh"

module ern_tick_divider (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic rtc_tick_in,
    output logic [`ERN_PIT_TAP_COUNT-1:0] periodic_tick_out
);
    logic [`ERN_PIT_CNT_W-1:0] cnt;

    // free running count; bit k toggles every 2**k ticks
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cnt <= '0;
        end else if (rtc_tick_in) begin
            cnt <= cnt + `ERN_PIT_CNT_W'(1);
        end
    end

    // bit 0 is divide by 64, bit 7 divide by 8192
    assign periodic_tick_out = cnt[`ERN_PIT_CNT_W-1:`ERN_PIT_FIRST_TAP];

    property p_pit_tap;
        @(posedge sys_clk_in) disable iff (rst_in)
        $changed(periodic_tick_out[0]) |-> $past(rtc_tick_in && cnt[4:0] == 5'h1f);
    endproperty
    a_pit_tap: assert property (p_pit_tap) else $error("divide-by-64 tap toggled off its count");

endmodule : ern_tick_divider

// ---- verification/ern_gen_model.sv ----
// generator peripherals standing at the far side of the event routing network
// assumes req_in is driven off the rising edge by the bench; bit classes follow the masks
`timescale 1ns/100ps

module ern_gen_model #(
    parameter logic [31:0] ASYNC_MASK = 32'h0000_00ff,
    parameter logic [31:0] PULSE_MASK = 32'h0000_ff00
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [31:0] req_in,
    input wire logic [5:0] async_delay_in,
    output logic [31:0] gen_event_out
);
    logic [31:0] async_lvl = '0;
    logic [31:0] sync_lvl;
    logic [31:0] req_q;
    logic [31:0] pulse;

    // pins, comparators, zero-cross, logic outputs: no clock, late by a bench-chosen delay
    always @(req_in) begin
        async_lvl <= #(async_delay_in) req_in & ASYNC_MASK;
    end

    // clocked levels change only on the edge; the bench holds them two cycles or more
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sync_lvl <= '0;
            req_q <= '0;
            pulse <= '0;
        end else begin
            sync_lvl <= req_in & ~ASYNC_MASK & ~PULSE_MASK;
            pulse <= req_in & ~req_q & PULSE_MASK; // one cycle per raised request
            req_q <= req_in;
        end
    end

    assign gen_event_out = async_lvl | sync_lvl | pulse;

endmodule : ern_gen_model

// ---- verification/testbench.sv ----
// self-checking bench for the event routing network
// assumes ern_gen_model for the generators; gens 0-7 async, 8-15 pulse, 16-31 clocked levels
`timescale 1ns/100ps

module testbench;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic rtc_tick_in = 1'b1;
    logic [31:0] req = 32'h0000_00ff;
    logic [5:0] dly = 6'h05;
    logic [31:0] gen_ev;
    logic [47:0] chan_sel = '0;
    logic [5:0] sw_ev = '0;
    logic [63:0] user_sel = {16{4'h1}};
    logic [15:0] pin_sel = '0;
    logic [3:0] count_sel = '0, restart_sel = '0, capture_sel = '0, en_sel = '0, dis_sel = '0;
    ern_pkg::ern_det_mode_t count_mode = ern_pkg::ERN_DET_RISE, restart_mode = ern_pkg::ERN_DET_RISE;
    logic count_dir = 1'b0, restart_dir = 1'b0, capture_async = 1'b0;
    logic [7:0] ptick;
    logic [15:0] ua, us;
    logic [3:0] pin_out;
    logic step, down, restart, cap, amp_en, amp_dis, dump, drive;
    int n_fail = 0, num_checks = 0, seed = 35157;

    always #25 sys_clk_in = ~sys_clk_in;

    ern_gen_model gens (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_in(req), .async_delay_in(dly),
        .gen_event_out(gen_ev));

    ern_event_router #(.GEN_ASYNC_MASK(32'h0000_00ff), .GEN_PULSE_MASK(32'h0000_ff00),
        .GEN_MIN2_MASK(32'hffff_0000)) dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .gen_event_in(gen_ev), .rtc_tick_in(rtc_tick_in),
        .periodic_tick_out(ptick), .chan_sel_in(chan_sel), .sw_event_in(sw_ev), .user_sel_in(user_sel),
        .user_async_out(ua), .user_sync_out(us), .event_pin_sel_in(pin_sel), .event_pin_output_out(pin_out),
        .count_sel_in(count_sel), .count_mode_in(count_mode), .count_dir_en_in(count_dir),
        .restart_sel_in(restart_sel), .restart_mode_in(restart_mode), .restart_dir_en_in(restart_dir),
        .count_step_out(step), .count_down_out(down), .restart_out(restart), .capture_sel_in(capture_sel),
        .capture_async_in(capture_async), .capture_edge_out(cap), .amp_enable_sel_in(en_sel),
        .amp_disable_sel_in(dis_sel), .amp_dump_sel_in(dis_sel), .amp_drive_sel_in(dis_sel),
        .amp_enable_out(amp_en), .amp_disable_out(amp_dis), .amp_dump_out(dump), .amp_drive_out(drive));

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cyc

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // distance between two rising edges of one tick tap, bounded wait
    task automatic period(input int k);
        int n, t;
        logic prev;
        n = 0;
        t = 0;
        prev = ptick[k];
        for (int i = 0; i < (300 << k) && n < 2; i++) begin
            cyc(1);
            if (prev === 1'b0 && ptick[k] === 1'b1) begin
                if (n == 1) check("tick period", 32'(i - t), 32'(64 << k));
                t = i;
                n++;
            end
            prev = ptick[k];
        end
        if (n < 2) begin
            n_fail++;
            complete_run();
        end
    endtask : period

    // main sequence: all inputs change at the falling edge
    initial begin : main
        int g, c, u, p, ncap, nen;
        ern_pkg::ern_det_mode_t modes [3];
        modes = '{ern_pkg::ERN_DET_RISE, ern_pkg::ERN_DET_ANY, ern_pkg::ERN_DET_HIGH};
        user_sel[63:56] = 8'h07; // user 15 unselected, user 14 out of range
        cyc(8);
        rst_in = 1'b0;
        cyc(1);
        check("async users, channels off", ua, 32'h0);
        check("sync users, channels off", us, 32'h0);
        check("registered user outputs", {step, down, restart, cap, amp_en, amp_dis, dump, drive}, 32'h0);
        req = '0;
        cyc(2);
        // random routes: async gens seen mid-cycle, before any edge
        for (int i = 0; i < 24; i++) begin
            g = $unsigned($random(seed)) % 8;
            c = $unsigned($random(seed)) % 6;
            u = $unsigned($random(seed)) % 14;
            p = $unsigned($random(seed)) % 4;
            dly = 6'(1 + $unsigned($random(seed)) % 20);
            chan_sel[c*8+:8] = 8'(g + 1);
            user_sel[u*4+:4] = 4'(c + 1);
            pin_sel[p*4+:4] = 4'(c + 1);
            req[g] = ~req[g];
            #(dly + 2);
            check("async user level", ua[u], req[g]);
            check("pin output level", pin_out[p], req[g]);
            check("unselected user", {ua[15:14], us[15:14]}, 32'h0);
            @(negedge sys_clk_in);
        end
        // ch0 async gen0, ch1 clocked level gen16, ch2 pulse gen8
        chan_sel = 48'h0000_0009_1101;
        user_sel[7:0] = 8'h31;
        req = '0;
        dly = 6'h05;
        cyc(4);
        req[0] = 1'b1;
        cyc(1);
        check("sync subchannel, one edge", us[0], 32'h0);
        cyc(1);
        check("sync subchannel, two edges", us[0], 32'h1);
        sw_ev = 6'h01;
        cyc(1);
        sw_ev = '0;
        check("software inversion", {ua[0], us[0]}, 32'h0);
        cyc(1);
        check("software inversion ends", {ua[0], us[0]}, 32'h3);
        // timer pulse into the synchronous capture input
        capture_sel = 4'h3;
        req[8] = 1'b1;
        cyc(1);
        check("pulse event", us[1], 32'h1);
        cyc(1);
        check("pulse lasts one cycle", us[1], 32'h0);
        check("sync capture edge", cap, 32'h1);
        cyc(1);
        check("capture edge one cycle", cap, 32'h0);
        req[8] = 1'b0;
        // detector modes on the clocked level of ch1
        count_sel = 4'h2;
        restart_sel = 4'h2;
        dis_sel = 4'h2;
        for (int i = 0; i < 3; i++) begin
            count_mode = modes[i];
            restart_mode = modes[i];
            count_dir = (i == 0);
            restart_dir = (i == 1);
            req[16] = 1'b0;
            cyc(4);
            req[16] = 1'b1;
            cyc(2);
            check("count step on rise", step, 32'h1);
            check("restart on rise", restart, 32'h1);
            check("count direction", down, 32'(i != 2));
            check("amp disable, dump, drive", {amp_dis, dump, drive}, 32'h7);
            cyc(1);
            check("count step held", step, 32'(i == 2));
            check("restart held", restart, 32'(i == 2));
            check("amp disable one cycle", amp_dis, 32'h0);
            req[16] = 1'b0;
            cyc(2);
            check("count step on fall", step, 32'(i == 1));
            check("restart on fall", restart, 32'(i == 1));
            check("direction and dump drop", {down, dump, drive}, 32'h0);
            cyc(1);
            check("count step idle", step, 32'h0);
        end
        // async capture and amplifier enable go through their own synchronisers
        capture_async = 1'b1;
        capture_sel = 4'h1;
        en_sel = 4'h1;
        req[0] = 1'b0;
        cyc(6);
        ncap = 0;
        nen = 0;
        req[0] = 1'b1;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            if (cap === 1'b1) ncap++;
            if (amp_en === 1'b1) nen++;
        end
        check("async capture pulses", 32'(ncap), 32'h1);
        check("amp enable pulses", 32'(nen), 32'h1);
        for (int k = 0; k < 3; k++) begin
            period(k);
        end
        complete_run();
    end

endmodule : testbench
